// File: verilog/isap_port.sv
// What this block does
// - slave-select value ignored; master and select-output bits pick role
// - master drives bit clock and word select; low left, high right
// - the first received word stored is a left word
// - mute zeroes output from next left word; FIFO still drains
// - pause from next left word stops DMA and FIFO, sends zeros
// - cleared pause resumes at next left word where it stopped
// - pause overrides mute
// - mono sends each word in both slots, keeps only left on receive
// - align bit 0 delays word one bit clock; 1 starts with select
// - write to full transmit FIFO sets transmit overrun, write 1 clears
// - pop from empty transmit FIFO sets underrun, write 1 clears
// - enabled master seeing select low sets collision, never in audio
// - early select release in slave sets abort, restart at bit 15
// - receive push into full FIFO sets receive overrun
// - every error sets its flag and the summary interrupt flag
// - data interrupt when last word gone and FIFO empty, not with DMA
// - force bit raises an interrupt request
// - master bit rate is clock over twice reload, zero means 65536
// - disabled port with timer enable runs timer, timeout sets summary
// - words leave MSB first; last received bit lands in bit 0
`timescale 1ns/10ps
`include "isap_defs.svh"
module isap_port
    import isap_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire isap_cfg_t   cfg,
    input  wire logic        force_irq,
    input  wire isap_clr_t   clr,
    input  wire logic        tx_wr_valid,
    input  wire logic [15:0] tx_wr_data,
    input  wire logic        rx_rd_req,
    output logic      [15:0] rx_rd_data,
    output logic             tx_dma_req,
    output logic             rx_dma_req,
    input  wire logic        bclk_in,
    input  wire logic        select_pin_in,
    input  wire logic        sdi_in,
    output isap_pin_t        pins,
    output isap_stat_t       stat,
    output logic             irq_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // pin synchronisers; stage zero only feeds stage one
    logic [2:0] bclk_s;
    logic [2:0] sel_s;
    logic [1:0] sdi_s;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bclk_s <= 3'h0;
            sel_s  <= 3'h7;
            sdi_s  <= 2'h0;
        end else begin
            bclk_s <= {bclk_s[1:0], bclk_in};
            sel_s  <= {sel_s[1:0], select_pin_in};
            sdi_s  <= {sdi_s[0], sdi_in};
        end
    end

    // role decode; the written select value is never consulted
    logic master;
    logic audio;
    logic run;
    logic gen_on;
    assign master = cfg.master_en & cfg.sel_out;
    assign audio  = cfg.i2s_en & ~cfg.clk_phase & ~cfg.clk_pol
                  & (cfg.char_len == `ISAP_LEN16);
    assign run    = cfg.port_en & audio;
    assign gen_on = (run & master) | (~cfg.port_en & cfg.gen_irq_en);

    // bit rate generator, also the idle timer
    logic [16:0] gen_q;
    logic [16:0] rl;
    logic        tick;
    assign rl   = (cfg.reload == 16'h0) ? `ISAP_ZERO_RL
                                        : {1'b0, cfg.reload};
    assign tick = gen_on & (gen_q == 17'h0);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gen_q <= 17'h0;
        end else if (~gen_on | tick) begin
            gen_q <= rl - 17'h1;
        end else begin
            gen_q <= gen_q - 17'h1;
        end
    end

    // bit clock: toggles per timeout, so period is twice the reload
    logic bclk_q;
    logic rise;
    logic fall;
    assign rise = master ? (tick & ~bclk_q) : (bclk_s[1] & ~bclk_s[2]);
    assign fall = master ? (tick & bclk_q) : (~bclk_s[1] & bclk_s[2]);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bclk_q <= 1'b0;
        end else if (~(run & master)) begin
            bclk_q <= 1'b0;
        end else if (tick) begin
            bclk_q <= ~bclk_q;
        end
    end

    // framing on the transmit edge; master counts 16 bits per half
    logic [3:0] cnt_q;
    logic       ws_q;
    logic       ws_seen_q;
    logic       chg_q;
    logic       chan_q;
    logic       ws_chg;
    logic       ws_new;
    logic       wstart;
    logic       wchan;
    logic       left;
    assign ws_chg = master ? (cnt_q == `ISAP_LAST) : (sel_s[1] != ws_seen_q);
    assign ws_new = master ? ~ws_q : sel_s[1];
    // delayed mode starts one bit clock after the select change
    assign wstart = run & fall
                  & (cfg.word_align_ctl ? ws_chg : chg_q);
    assign wchan  = cfg.word_align_ctl ? ws_new : chan_q;
    assign left   = (wchan == `ISAP_LEFT);
    always_ff @(posedge clk_sys) begin
        if (rst | ~run) begin
            cnt_q     <= 4'h0;
            ws_q      <= 1'b1;
            ws_seen_q <= 1'b1;
            chg_q     <= 1'b0;
            chan_q    <= 1'b1;
        end else if (fall) begin
            if (master) begin
                cnt_q <= cnt_q + 4'h1;
            end
            if (master & ws_chg) begin
                ws_q <= ~ws_q;
            end
            if (ws_chg) begin
                ws_seen_q <= ws_new;
                chan_q    <= ws_new;
            end
            chg_q <= ws_chg;
        end
    end

    // mute and pause only change at a left word boundary
    logic sync_q;
    logic mute_q;
    logic pause_q;
    logic pause_e;
    logic mute_e;
    logic go;
    logic tx_want;
    assign pause_e = left ? cfg.pause : pause_q;
    assign mute_e  = left ? cfg.mute : mute_q;
    assign go      = sync_q | left;
    assign tx_want = go & ~pause_e & ~(cfg.mono & ~left);
    always_ff @(posedge clk_sys) begin
        if (rst | ~run) begin
            sync_q  <= 1'b0;
            mute_q  <= 1'b0;
            pause_q <= 1'b0;
        end else if (wstart & left) begin
            sync_q  <= 1'b1;
            mute_q  <= cfg.mute;
            pause_q <= cfg.pause;
        end
    end

    // transmit FIFO, sixteen words
    logic [15:0] tx_mem [`ISAP_DEPTH];
    logic [3:0]  tx_wp;
    logic [3:0]  tx_rp;
    logic [4:0]  tx_cnt;
    logic        tx_full;
    logic        tx_empty;
    logic        tx_push;
    logic        tx_pop;
    assign tx_full  = (tx_cnt == `ISAP_DEPTH);
    assign tx_empty = (tx_cnt == 5'h0);
    assign tx_push  = tx_wr_valid & ~tx_full;
    assign tx_pop   = wstart & tx_want & ~tx_empty;
    always_ff @(posedge clk_sys) begin
        if (tx_push) begin
            tx_mem[tx_wp] <= tx_wr_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_wp  <= 4'h0;
            tx_rp  <= 4'h0;
            tx_cnt <= 5'h0;
        end else begin
            tx_wp  <= tx_wp + {3'h0, tx_push};
            tx_rp  <= tx_rp + {3'h0, tx_pop};
            tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
        end
    end

    // word chosen at each start; muted words still drain the FIFO
    logic [15:0] word;
    logic [15:0] sh_q;
    logic [15:0] hold_q;
    logic        sdo_q;
    logic        tx_live_q;
    always_comb begin
        word = 16'h0;
        if (tx_pop & ~mute_e) begin
            word = tx_mem[tx_rp];
        end
        if (go & ~pause_e & cfg.mono & ~left) begin
            word = hold_q;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst | ~run) begin
            sh_q      <= 16'h0;
            sdo_q     <= 1'b0;
            hold_q    <= 16'h0;
            tx_live_q <= 1'b0;
        end else if (wstart) begin
            sh_q      <= word;
            sdo_q     <= word[`ISAP_MSB];
            tx_live_q <= tx_pop;
            if (left) begin
                hold_q <= word;
            end
        end else if (fall) begin
            sh_q  <= {sh_q[`ISAP_MSB-1:0], 1'b0};
            sdo_q <= sh_q[`ISAP_MSB-1];
        end
    end

    // receive shifter; completed word is pushed at next word start
    logic [15:0] rx_sh_q;
    logic        rx_arm_q;
    logic        rx_chan_q;
    logic        rx_push;
    always_ff @(posedge clk_sys) begin
        if (rst | ~run) begin
            rx_sh_q   <= 16'h0;
            rx_arm_q  <= 1'b0;
            rx_chan_q <= 1'b1;
        end else begin
            if (rise) begin
                rx_sh_q <= {rx_sh_q[`ISAP_MSB-1:0], sdi_s[1]};
            end
            if (wstart) begin
                rx_arm_q  <= go & ~pause_e;
                rx_chan_q <= wchan;
            end
        end
    end
    assign rx_push = wstart & rx_arm_q
                   & ~(cfg.mono & (rx_chan_q != `ISAP_LEFT));

    // receive FIFO; a push when full is dropped
    logic [15:0] rx_mem [`ISAP_DEPTH];
    logic [3:0]  rx_wp;
    logic [3:0]  rx_rp;
    logic [4:0]  rx_cnt;
    logic        rx_full;
    logic        rx_empty;
    logic        rx_in;
    logic        rx_pop;
    logic [15:0] rx_rd_q;
    assign rx_full  = (rx_cnt == `ISAP_DEPTH);
    assign rx_empty = (rx_cnt == 5'h0);
    assign rx_in    = rx_push & ~rx_full;
    assign rx_pop   = rx_rd_req & ~rx_empty;
    always_ff @(posedge clk_sys) begin
        if (rx_in) begin
            rx_mem[rx_wp] <= rx_sh_q;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_wp   <= 4'h0;
            rx_rp   <= 4'h0;
            rx_cnt  <= 5'h0;
            rx_rd_q <= 16'h0;
        end else begin
            rx_wp  <= rx_wp + {3'h0, rx_in};
            rx_rp  <= rx_rp + {3'h0, rx_pop};
            rx_cnt <= rx_cnt + {4'h0, rx_in} - {4'h0, rx_pop};
            if (rx_pop) begin
                rx_rd_q <= rx_mem[rx_rp];
            end
        end
    end

    // DMA requests held off while paused
    logic txd_q;
    logic rxd_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txd_q <= 1'b0;
            rxd_q <= 1'b0;
        end else begin
            txd_q <= run & cfg.tx_dma_en & ~pause_q & ~tx_full;
            rxd_q <= run & cfg.rx_dma_en & ~pause_q & ~rx_empty;
        end
    end

    // plain serial faults; neither can fire with audio enabled
    logic [3:0] spi_bits_q;
    logic       spi_slave;
    assign spi_slave = cfg.port_en & ~cfg.i2s_en & ~master;
    always_ff @(posedge clk_sys) begin
        if (rst | ~spi_slave | sel_s[1]) begin
            spi_bits_q <= 4'h0;
        end else if (rise) begin
            spi_bits_q <= spi_bits_q + 4'h1;
        end
    end

    // sticky error flags; a set in the clear cycle wins
    isap_err_t err_set;
    isap_err_t err_q;
    assign err_set[`ISAP_E_TOVR] = tx_wr_valid & tx_full;
    assign err_set[`ISAP_E_TUND] = wstart & tx_want & tx_empty;
    assign err_set[`ISAP_E_ROVR] = rx_push & rx_full;
    assign err_set[`ISAP_E_COL]  = cfg.port_en & ~cfg.i2s_en
                                 & master & ~sel_s[1];
    assign err_set[`ISAP_E_ABT]  = spi_slave & sel_s[1] & ~sel_s[2]
                                 & (spi_bits_q != 4'h0);
    genvar gi;
    generate
        for (gi = 0; gi < `ISAP_NERR; gi++) begin : g_err
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    err_q[gi] <= 1'b0;
                end else if (err_set[gi]) begin
                    err_q[gi] <= 1'b1;
                end else if (clr.err[gi]) begin
                    err_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // summary flag; clears only once no error flag would remain
    logic irq_q;
    logic irq_d;
    logic irq_out_q;
    logic data_evt;
    logic irq_set;
    assign data_evt = wstart & tx_live_q & tx_empty
                    & ~cfg.tx_dma_en & ~cfg.rx_dma_en;
    assign irq_set  = (|err_set) | data_evt | force_irq
                    | (tick & ~cfg.port_en);
    always_comb begin
        irq_d = irq_q;
        if (irq_set) begin
            irq_d = 1'b1;
        end else if (clr.irq & ((err_q & ~clr.err) == '0)) begin
            irq_d = 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q     <= 1'b0;
            irq_out_q <= 1'b0;
        end else begin
            irq_q     <= irq_d;
            irq_out_q <= irq_d & cfg.irq_en;
        end
    end

    // pin enables; low while this end drives clock and select
    logic oe_n_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~(run & master);
        end
    end

    assign pins       = '{bclk_q, oe_n_q, ws_q, oe_n_q, sdo_q};
    assign stat       = '{irq_q, err_q, tx_live_q, sel_s[1]};
    assign irq_out    = irq_out_q;
    assign rx_rd_data = rx_rd_q;
    assign tx_dma_req = txd_q;
    assign rx_dma_req = rxd_q;

    property p_tovr;
        tx_wr_valid & tx_full |=> err_q[`ISAP_E_TOVR] && irq_q;
    endproperty
    a_tovr: assert property (p_tovr)
        else $error("overrun write not flagged");
    property p_tund;
        err_set[`ISAP_E_TUND] |-> !tx_pop ##1 err_q[`ISAP_E_TUND];
    endproperty
    a_tund: assert property (p_tund)
        else $error("underrun not flagged");
    property p_rovr;
        rx_push & rx_full |=> err_q[`ISAP_E_ROVR] && $stable(rx_wp);
    endproperty
    a_rovr: assert property (p_rovr)
        else $error("receive overrun mishandled");
    property p_force;
        force_irq & cfg.irq_en |=> irq_q && irq_out;
    endproperty
    a_force: assert property (p_force)
        else $error("forced interrupt missing");
    property p_pause;
        wstart & pause_e |-> !tx_pop ##1 (sh_q == 16'h0 && !pins.sdo);
    endproperty
    a_pause: assert property (p_pause)
        else $error("paused word not zero");
    property p_mono;
        wstart & go & ~pause_e & cfg.mono & ~left
            |-> !tx_pop ##1 sh_q == hold_q;
    endproperty
    a_mono: assert property (p_mono)
        else $error("mono right slot not repeated");
    property p_rate;
        tick && gen_on && cfg.reload == 16'h4
            |=> !tick [*3] ##1 (tick || !gen_on || cfg.reload != 16'h4);
    endproperty
    a_rate: assert property (p_rate)
        else $error("bit rate period wrong");
    property p_tmo;
        tick & ~cfg.port_en |=> irq_q;
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("timer timeout lost");
    property p_half;
        run & master & fall & (cnt_q != `ISAP_LAST) |=> $stable(ws_q);
    endproperty
    a_half: assert property (p_half)
        else $error("select toggled mid word");
endmodule

// File: verilog/isap_defs.svh
`ifndef ISAP_DEFS_SVH
`define ISAP_DEFS_SVH
`define ISAP_WBITS 16
`define ISAP_MSB 15
`define ISAP_DEPTH 5'h10
`define ISAP_LAST 4'hF
`define ISAP_LEN16 4'h0
`define ISAP_ZERO_RL 17'h10000
`define ISAP_LEFT 1'b0
`define ISAP_NERR 5
`define ISAP_E_TUND 0
`define ISAP_E_ROVR 1
`define ISAP_E_ABT 2
`define ISAP_E_COL 3
`define ISAP_E_TOVR 4
`endif

// File: verilog/isap_pkg.sv
`include "isap_defs.svh"
package isap_pkg;
    typedef logic [`ISAP_NERR-1:0] isap_err_t;
    // software configuration, held steady by the owner
    typedef struct packed {
        logic       port_en;
        logic       i2s_en;
        logic       master_en;
        logic       sel_out;
        logic       clk_phase;
        logic       clk_pol;
        logic [3:0] char_len;
        logic       mute;
        logic       pause;
        logic       mono;
        logic       word_align_ctl;
        logic       irq_en;
        logic       gen_irq_en;
        logic       rx_dma_en;
        logic       tx_dma_en;
        logic [15:0] reload;
    } isap_cfg_t;
    // one-cycle write-one-to-clear strobes
    typedef struct packed {
        logic      irq;
        isap_err_t err;
    } isap_clr_t;
    typedef struct packed {
        logic      irq;
        isap_err_t err;
        logic      busy;
        logic      sel;
    } isap_stat_t;
    typedef struct packed {
        logic bclk;
        logic bclk_oe_n;
        logic word_select;
        logic ws_oe_n;
        logic sdo;
    } isap_pin_t;
endpackage

// File: verif/isap_codec.sv
`timescale 1ns/10ps
// behavioural codec in the slave role: follows the port's clock and select
module isap_codec #(
    parameter logic [15:0] LW = 16'hC35A,
    parameter logic [15:0] RW = 16'h3A96
) (
    input  wire logic        rst,
    input  wire logic        bclk,
    input  wire logic        ws,
    input  wire logic        sdo,
    input  wire logic        align,
    output logic             sdi       = 1'b0,
    output logic      [15:0] word_q    = 16'h0000,
    output logic             word_left = 1'b0,
    output logic      [7:0]  n_words   = 8'h00
);
    logic [15:0] tsh  = 16'h0000;
    logic [15:0] rsh  = 16'h0000;
    logic        ws_t = 1'b1;
    logic        ws_r = 1'b1;

    // the port restarts with select high; forget the old channel at
    // release, when no bit clock edge can race the update
    always @(negedge rst) begin
        ws_t = 1'b1;
        ws_r = 1'b1;
    end

    // launch after the falling edge, late enough for select to settle
    always @(negedge bclk) begin
        #1;
        if (align && ws != ws_t)
            tsh = ws ? RW : LW;
        sdi = tsh[15];
        tsh = tsh << 1;
        if (!align && ws != ws_t)
            tsh = ws ? RW : LW;
        ws_t = ws;
    end

    // capture on the rising edge; a select change closes the word
    always @(posedge bclk) begin
        #1;
        if (ws != ws_r) begin
            word_q    = align ? rsh : {rsh[14:0], sdo};
            word_left = ~ws_r;
            n_words   = n_words + 8'h01;
        end
        rsh  = {rsh[14:0], sdo};
        ws_r = ws;
    end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import isap_pkg::*;
;
    localparam logic [15:0] LW = 16'hC35A;
    localparam logic [15:0] RW = 16'h3A96;
    logic        clk_sys     = 1'b0;
    logic        rst         = 1'b1;
    isap_cfg_t   cfg         = '0;
    logic        force_irq   = 1'b0;
    isap_clr_t   clr         = '0;
    logic        tx_wr_valid = 1'b0;
    logic [15:0] tx_wr_data  = 16'h0000;
    logic        rx_rd_req   = 1'b0;
    logic        sel_in      = 1'b1;
    logic [15:0] rx_rd_data;
    logic        tx_dma_req;
    logic        rx_dma_req;
    isap_pin_t   pins;
    isap_stat_t  stat;
    logic        irq_out;
    logic        sdi;
    logic [15:0] cw;
    logic        cw_left;
    logic [7:0]  n_words;
    int          cyc         = 0;
    int          n_fail      = 0;
    int          checks      = 0;

    // 125 MHz clock and a cycle count for interval checks
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    isap_port isap_port_inst (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .cfg           (cfg),
        .force_irq     (force_irq),
        .clr           (clr),
        .tx_wr_valid   (tx_wr_valid),
        .tx_wr_data    (tx_wr_data),
        .rx_rd_req     (rx_rd_req),
        .rx_rd_data    (rx_rd_data),
        .tx_dma_req    (tx_dma_req),
        .rx_dma_req    (rx_dma_req),
        .bclk_in       (1'b0),
        .select_pin_in (sel_in),
        .sdi_in        (sdi),
        .pins          (pins),
        .stat          (stat),
        .irq_out       (irq_out)
    );

    isap_codec #(.LW(LW), .RW(RW)) isap_codec_inst (
        .rst       (rst),
        .bclk      (pins.bclk),
        .ws        (pins.word_select),
        .sdo       (pins.sdo),
        .align     (cfg.word_align_ctl),
        .sdi       (sdi),
        .word_q    (cw),
        .word_left (cw_left),
        .n_words   (n_words)
    );

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        cfg <= '0;
        sel_in <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    // one-cycle clear strobe; flags are settled on return
    task automatic pulse_clr(input logic [5:0] c);
        @(posedge clk_sys);
        clr <= c;
        @(posedge clk_sys);
        clr <= '0;
        #1;
    endtask

    task automatic wr(input logic [15:0] d);
        @(posedge clk_sys);
        tx_wr_valid <= 1'b1;
        tx_wr_data  <= d;
        @(posedge clk_sys);
        tx_wr_valid <= 1'b0;
    endtask

    // data is registered on the same edge as the pop; one extra edge is waited after it
    task automatic rd();
        @(posedge clk_sys);
        rx_rd_req <= 1'b1;
        @(posedge clk_sys);
        rx_rd_req <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    // note when the summary flag rises, then clear it
    task automatic wait_irq(output int t);
        int i;
        i = 0;
        do begin
            @(posedge clk_sys);
            #1;
            i++;
        end while (stat.irq !== 1'b1 && i < 200);
        t = cyc;
        pulse_clr(6'h20);
    endtask

    task automatic t_reset();
        #1;
        check("reset stat", {stat.irq, stat.err, stat.busy, irq_out},
              8'h00);
        check("reset pins", {pins, tx_dma_req, rx_dma_req},
              7'b0111000);
        check("reset rx", rx_rd_data, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_flags();
        int i;
        @(posedge clk_sys);
        cfg.irq_en <= 1'b1;
        force_irq  <= 1'b1;
        @(posedge clk_sys);
        force_irq <= 1'b0;
        #1;
        check("forced", {stat.irq, irq_out}, 2'b11);
        pulse_clr(6'h20);
        check("forced clr", {stat.irq, irq_out}, 2'b00);
        // port idle, so the sixteen-deep buffer only fills
        for (i = 0; i < 17; i++)
            wr(16'(i));
        repeat (2) @(posedge clk_sys);
        #1;
        check("ovr", {stat.irq, stat.err, irq_out}, 7'h61);
        pulse_clr(6'h20);
        check("lone clr", {stat.irq, stat.err, irq_out}, 7'h61);
        pulse_clr(6'h30);
        check("both clr", {stat.irq, stat.err, irq_out}, 7'h00);
        @(posedge clk_sys);
        cfg.port_en   <= 1'b1;
        cfg.master_en <= 1'b1;
        cfg.sel_out   <= 1'b1;
        sel_in        <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        check("collision", {stat.irq, stat.err[3]}, 2'b11);
        check("select seen", stat.sel, 1'b0);
        $display("test flags done");
    endtask

    task automatic t_timer();
        int t1;
        int t2;
        do_reset();
        // count first, enable next: the generator loads the reload while stopped and at each timeout
        @(posedge clk_sys);
        cfg.reload     <= 16'h0006;
        @(posedge clk_sys);
        cfg.gen_irq_en <= 1'b1;
        wait_irq(t1);
        wait_irq(t2);
        check("timer gap", 16'(t2 - t1), 16'h0006);
        $display("test timer done");
    endtask

    // m: 0 stereo, 1 aligned, 2 mono, 3 mute, 4 pause then resume
    task automatic t_audio(input int m);
        logic [15:0] w [4];
        logic [15:0] e;
        isap_cfg_t   c;
        int          k;
        int          t0;
        do_reset();
        for (k = 0; k < ((m == 2) ? 2 : 4); k++) begin
            w[k] = 16'h8421 + 16'(k) * 16'h1111;
            wr(w[k]);
        end
        c                = '0;
        c.i2s_en         = 1'b1;
        c.master_en      = 1'b1;
        c.sel_out        = 1'b1;
        c.reload         = 16'h0004;
        c.word_align_ctl = (m == 1);
        c.mono           = (m == 2);
        c.mute           = (m == 3);
        c.pause          = (m == 4);
        c.rx_dma_en      = 1'b1;
        c.tx_dma_en      = 1'b1;
        c.irq_en         = 1'b1;
        @(posedge clk_sys);
        cfg    <= c;
        sel_in <= 1'b0;
        // port enable last, once reload and mode have settled
        @(posedge clk_sys);
        cfg.port_en <= 1'b1;
        if (m == 0) begin
            @(posedge pins.bclk);
            t0 = cyc;
            @(posedge pins.bclk);
            check("bclk period", 16'(cyc - t0), 16'h0008);
            check("pin drive", {pins.bclk_oe_n, pins.ws_oe_n}, 2'b00);
        end
        // skip the idle right slot that opens the first frame
        k = 0;
        while (k < 4) begin
            @(n_words);
            if (k > 0 || cw_left) begin
                e = (m > 2) ? 16'h0000 : (m == 2) ? w[k / 2] : w[k];
                check("codec word", cw, e);
                check("codec side", cw_left, k % 2 == 0);
                k++;
            end
        end
        // the aligned run waits long enough to fill the receive buffer
        repeat ((m == 1) ? 2300 : 300) @(posedge clk_sys);
        #1;
        check("underrun", {stat.err[0], irq_out}, {2{m != 4}});
        check("rx overrun", stat.err[1], m == 1);
        check("no collision", stat.err[3], 1'b0);
        if (m < 4) begin
            check("dma req", {tx_dma_req, rx_dma_req}, 2'b11);
            rd();
            check("rx first", rx_rd_data, LW);
            rd();
            check("rx second", rx_rd_data, (m == 2) ? LW : RW);
        end else begin
            check("pause dma", {tx_dma_req, rx_dma_req}, 2'b00);
            @(posedge clk_sys);
            cfg.pause <= 1'b0;
            do @(n_words); while (cw_left);
            @(n_words);
            check("resume word", cw, w[0]);
        end
        $display("test audio %0d done", m);
    endtask

    // the whole run is a few thousand cycles; this only cuts a hang
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        end_of_test();
    end

    initial begin
        do_reset();
        t_reset();
        t_flags();
        t_timer();
        for (int m = 0; m < 5; m++)
            t_audio(m);
        end_of_test();
    end
endmodule
